/* File: sfrc_dev.sv */
/*
  sfrc_dev: device end of the serial flash read link. Decodes status
  write, plain, fast, double-rate, dual, quad and dual I/O reads and
  the read-parameter command, streams a small memory array out.
  Assumes the host makes sclk slow enough for pclk to see each level
  for several cycles; link pins are synchronised before use.
*/
// Decided for this implementation: the APB interface to the registers and the address map.
// Functional notes
// RL1: sixteen data bits write both status registers
// RL2: eight bits write only status one
// RL3: plain read takes opcode, 24-bit address
// RL4: data changes on falling edge, msb first
// RL5: address increments per byte until deselect
// RL6: reads ignored while busy, cycle untouched; continuous-mode reads started at select skip the busy_in check
// RL7: plain read refused in four-lane mode
// RL8: fast read waits eight dummy clocks
// RL9: four-lane dummy count two to eight
// RL10: dummy count two after reset command
// RL11: double-rate read, six dummy clocks
// RL12: dual output after eight dummy clocks
// RL13: lane zero even bits, lane one odd
// RL14: host releases lanes before data out
// RL15: quad output needs quad permit bit
// RL16: dual I/O address two bits per clock
// RL17: eight continuous read bits follow address
// RL18: key one-zero skips the next opcode
// RL19: other key restores opcode decoding
// RL20: host exits with sixteen ones on lane zero
// RL21: lanes enabled only from first data clock
`timescale 1ns/1ps
`default_nettype none
module sfrc_dev
  import sfrc_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  sfrc_link_if.dev lnk,
  input wire logic busy_in,
  input wire logic four_lane_command_mode,
  input wire logic mem_we,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] status1,
  output logic [7:0] status2,
  output logic [1:0] read_param,
  output logic cont_mode
);
  typedef struct packed {
    sfrc_dst_t st;
    logic [7:0] op;
    logic [1:0] aw;
    logic [1:0] dw;
    logic ddr;
    logic [5:0] cnt;
    logic [5:0] tgt;
    logic [23:0] sh;
    logic [23:0] addr;
    logic [7:0] ob;
    logic [3:0] rem;
    logic cont;
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [1:0] rp;
    logic [3:0] dout;
    logic [3:0] doe;
    logic sclk_p;
    logic cs_p;
  } sfrc_dstate_t;

  localparam sfrc_dstate_t DEV_RST = '{st: D_IDLE, sr1: SR1_RST,
                                       sr2: SR2_RST, rp: RP_RST,
                                       cs_p: 1'b1, default: '0};
  localparam logic [5:0] SYNC_RST = 6'h10;

  sfrc_dstate_t q;
  sfrc_dstate_t d;
  logic [7:0] mem [2**MEM_AW];
  logic sclk_s;
  logic cs_s;
  logic [3:0] io_s;
  logic rise;
  logic fall;
  logic samp;
  logic cap;
  logic [2:0] n;
  logic [2:0] n2;
  logic [7:0] nb;
  logic [5:0] qdum;
  logic rd_ok;

  sfrc_sync #(.W(6), .RST(SYNC_RST)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({lnk.sclk, lnk.cs_n, lnk.io}),
    .dout({sclk_s, cs_s, io_s})
  );

  assign rise = sclk_s & ~q.sclk_p;
  assign fall = ~sclk_s & q.sclk_p;

  // contents come from the user side; no reset on the array
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always_comb begin
    d = q;
    samp = 1'b0;
    cap = 1'b0;
    n = lane_n(q.aw);
    n2 = lane_n(q.dw);
    nb = '0;
    qdum = 6'({3'h0, q.rp, 1'b0}) + QDUM_MIN; // [RL9]
    rd_ok = ~busy_in; // [RL6]
    d.sclk_p = sclk_s;
    d.cs_p = cs_s;
    if (cs_s) begin
      d.st = D_IDLE;
      d.doe = '0;
      if (!q.cs_p && q.st == D_WSR) begin
        if (q.cnt == WSR_BITS) begin
          d.sr1 = q.sh[15:8]; // [RL1]
          d.sr2 = q.sh[7:0]; // [RL1]
        end else if (q.cnt >= SR1_BITS) begin
          d.sr1 = 8'(q.sh >> (q.cnt - SR1_BITS)); // [RL2]
        end
        // quad permit is locked while in four-lane mode
        if (four_lane_command_mode) begin
          d.sr2[QP_BIT_POS] = q.sr2[QP_BIT_POS];
        end
      end
    end else if (q.cs_p) begin
      d.cnt = '0;
      d.ddr = 1'b0;
      d.doe = '0;
      if (q.cont) begin
        d.st = D_ADDR; // [RL18]
        d.op = OP_DIO;
        d.aw = W2;
        d.dw = W2;
        d.tgt = '0;
      end else begin
        d.st = D_CMD; // [RL19]
        d.aw = four_lane_command_mode ? W4 : W1;
      end
    end else begin
      samp = rise | (q.ddr & fall & (q.st == D_ADDR)); // [RL11]
      cap = samp & ((q.st == D_CMD) | (q.st == D_ADDR) |
                    (q.st == D_MODE) | (q.st == D_PARAM) |
                    ((q.st == D_WSR) & (q.cnt < WSR_BITS))); // [RL3]
      if (cap) begin
        d.sh = (q.sh << n) | 24'(in_bits(io_s, q.aw, 1'b0)); // [RL16]
        d.cnt = q.cnt + 6'(n);
      end
      unique case (q.st)
        D_CMD: begin
          if (cap && d.cnt == CMD_BITS) begin
            d.op = d.sh[7:0];
            d.cnt = '0;
            d.st = D_SKIP;
            d.dw = q.aw;
            case (d.sh[7:0])
              OP_WSR: d.st = D_WSR;
              OP_READ: begin
                if (!four_lane_command_mode && rd_ok) begin // [RL7]
                  d.st = D_ADDR;
                  d.tgt = '0;
                end
              end
              OP_FAST: begin
                if (rd_ok) begin
                  d.st = D_ADDR;
                  d.tgt = four_lane_command_mode ? qdum : DUM_SPI; // [RL8]
                end
              end
              OP_DTR: begin
                if (rd_ok) begin
                  d.st = D_ADDR;
                  d.ddr = 1'b1; // [RL11]
                  d.tgt = DUM_DTR; // [RL11]
                end
              end
              OP_DUAL: begin
                if (!four_lane_command_mode && rd_ok) begin
                  d.st = D_ADDR;
                  d.dw = W2; // [RL12]
                  d.tgt = DUM_SPI; // [RL12]
                end
              end
              OP_QUAD: begin
                if (!four_lane_command_mode && rd_ok &&
                    q.sr2[QP_BIT_POS]) begin // [RL15]
                  d.st = D_ADDR;
                  d.dw = W4;
                  d.tgt = DUM_SPI;
                end
              end
              OP_DIO: begin
                if (!four_lane_command_mode && rd_ok) begin
                  d.st = D_ADDR;
                  d.aw = W2; // [RL16]
                  d.dw = W2;
                  d.tgt = '0;
                end
              end
              OP_SETP: begin
                if (four_lane_command_mode) begin
                  d.st = D_PARAM;
                end
              end
              OP_RST: d.rp = RP_RST; // [RL10]
              default: d.st = D_SKIP;
            endcase
          end
        end
        D_ADDR: begin
          if (cap && d.cnt == ADDR_BITS) begin
            d.addr = d.sh; // [RL3]
            d.cnt = '0;
            d.rem = '0;
            if (q.op == OP_DIO) begin
              d.st = D_MODE; // [RL17]
            end else if (q.tgt == '0) begin
              d.st = D_DATA;
            end else begin
              d.st = D_DUMMY;
            end
          end
        end
        D_MODE: begin
          if (cap && d.cnt == MODE_BITS) begin
            // low nibble of the continuous read bits is ignored
            d.cont = d.sh[CONT_HI:CONT_LO] == CONT_KEY; // [RL17] [RL18]
            d.st = D_DATA;
          end
        end
        D_PARAM: begin
          if (cap && d.cnt == CMD_BITS) begin
            d.rp = d.sh[RP_HI:RP_LO]; // [RL9]
            d.st = D_SKIP;
          end
        end
        D_DUMMY: begin
          // lanes stay released; input on them is not looked at
          if (rise) begin
            d.cnt = q.cnt + 6'h01; // [RL8] [RL12]
            if (d.cnt == q.tgt) begin
              d.st = D_DATA;
            end
          end
        end
        D_DATA: begin
          if (fall || (q.ddr && rise)) begin // [RL4] [RL11]
            nb = (q.rem == '0) ? mem[q.addr[MEM_AW-1:0]] : q.ob;
            if (q.rem == '0) begin
              d.addr = q.addr + 24'h000001; // [RL5]
            end
            d.dout = top_bits(nb, q.dw, 1'b1); // [RL4] [RL13]
            d.doe = lane_mask(q.dw, 1'b1); // [RL21]
            d.ob = nb << n2;
            d.rem = ((q.rem == '0) ? BYTE_BITS : q.rem) - 4'(n2);
          end
        end
        D_WSR, D_SKIP, D_IDLE: ;
        default: d.st = D_SKIP;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  assign lnk.dev_o = q.dout;
  assign lnk.dev_oe = q.doe;
  assign status1 = q.sr1;
  assign status2 = q.sr2;
  assign read_param = q.rp;
  assign cont_mode = q.cont;
endmodule : sfrc_dev
`default_nettype wire

/* File: sfrc_pkg.sv */
/*
  sfrc_pkg: constants, state encodings and lane helpers shared by both
  ends of the serial flash read link and the host register map.
  Assumes a 200 MHz pclk and a link clock made by the host end.
*/
`default_nettype none
package sfrc_pkg;
  // lane width codes
  localparam logic [1:0] W1 = 2'h0;
  localparam logic [1:0] W2 = 2'h1;
  localparam logic [1:0] W4 = 2'h2;
  // opcodes
  localparam logic [7:0] OP_WSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DTR = 8'h0d;
  localparam logic [7:0] OP_DUAL = 8'h3b;
  localparam logic [7:0] OP_QUAD = 8'h6b;
  localparam logic [7:0] OP_DIO = 8'hbb;
  localparam logic [7:0] OP_SETP = 8'hc0;
  localparam logic [7:0] OP_RST = 8'h99;
  // phase lengths in bits or clocks
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] SR1_BITS = 6'h08;
  localparam logic [5:0] WSR_BITS = 6'h10;
  localparam logic [5:0] DUM_SPI = 6'h08;
  localparam logic [5:0] DUM_DTR = 6'h06;
  localparam logic [5:0] QDUM_MIN = 6'h02;
  localparam logic [5:0] EXIT_BITS = 6'h10;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // status and parameter fields
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam logic [7:0] SR2_RST = 8'h00;
  localparam logic [1:0] RP_RST = 2'h0;
  localparam int QP_BIT_POS = 1;
  localparam int CONT_HI = 5;
  localparam int CONT_LO = 4;
  localparam logic [1:0] CONT_KEY = 2'h2;
  localparam int RP_HI = 5;
  localparam int RP_LO = 4;
  // host register map and fields
  localparam logic [11:0] H_CFG = 12'h000;
  // distinct from the opcode phase state of the host machine
  localparam logic [11:0] H_OPCODE = 12'h004;
  localparam logic [11:0] H_TXD = 12'h008;
  localparam logic [11:0] H_CMD = 12'h00c;
  localparam logic [11:0] H_RXD = 12'h010;
  localparam int OPEN_POS = 0;
  localparam int OPW_LO = 1;
  localparam int TXW_LO = 3;
  localparam int RXW_LO = 5;
  localparam int TXLEN_LO = 8;
  localparam int DUM_LO = 16;
  localparam int RXB_LO = 20;
  localparam int START_POS = 0;
  localparam int EXIT_POS = 1;
  // link clock timing
  localparam int PCLK_NS = 5;
  localparam int LINK_NS = 125;
  localparam int SCLK_HALF = (LINK_NS + 2 * PCLK_NS - 1) / (2 * PCLK_NS);

  typedef enum logic [3:0] {
    D_IDLE = 4'h0, D_CMD = 4'h1, D_ADDR = 4'h2, D_MODE = 4'h3,
    D_DUMMY = 4'h4, D_DATA = 4'h5, D_WSR = 4'h6, D_PARAM = 4'h7,
    D_SKIP = 4'h8
  } sfrc_dst_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_OPC = 3'h1, H_TX = 3'h2, H_DUM = 3'h3,
    H_RX = 3'h4, H_END = 3'h5
  } sfrc_hst_t;

  function automatic logic [2:0] lane_n(input logic [1:0] c);
    lane_n = (c == W2) ? 3'h2 : ((c == W4) ? 3'h4 : 3'h1);
  endfunction : lane_n

  // lone selects lane one for single-lane traffic
  function automatic logic [3:0] lane_mask(input logic [1:0] c,
                                           input logic lone);
    if (c == W4) lane_mask = 4'hf;
    else if (c == W2) lane_mask = 4'h3;
    else lane_mask = lone ? 4'h2 : 4'h1;
  endfunction : lane_mask

  function automatic logic [3:0] top_bits(input logic [7:0] b,
                                          input logic [1:0] c,
                                          input logic lone);
    if (c == W4) top_bits = b[7:4];
    else if (c == W2) top_bits = {2'h0, b[7:6]};
    else top_bits = lone ? {2'h0, b[7], 1'b0} : {3'h0, b[7]};
  endfunction : top_bits

  function automatic logic [3:0] in_bits(input logic [3:0] io,
                                         input logic [1:0] c,
                                         input logic lone);
    if (c == W4) in_bits = io;
    else if (c == W2) in_bits = {2'h0, io[1:0]};
    else in_bits = {3'h0, lone ? io[1] : io[0]};
  endfunction : in_bits
endpackage : sfrc_pkg
`default_nettype wire

/* File: sfrc_link_if.sv */
/*
  sfrc_link_if: the four-lane serial flash link between host and device.
  Each lane is resolved from both ends' enables; an undriven lane reads
  high, as a pull-up would make it.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfrc_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] io;

  // device wins a contended lane; the checker flags contention
  assign io = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) |
              (~dev_oe & ~host_oe);

  modport host (output sclk, output cs_n, output host_o, output host_oe,
                input io);
  modport dev (input sclk, input cs_n, input io, output dev_o,
               output dev_oe);
endinterface : sfrc_link_if
`default_nettype wire

/* File: sfrc_sync.sv */
/*
  sfrc_sync: two-flop synchroniser for a bundle of independent levels.
  Assumes each bit may change at any time relative to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sfrc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfrc_sync_t;

  sfrc_sync_t q;
  sfrc_sync_t d;

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{s1: RST, s2: RST};
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule : sfrc_sync
`default_nettype wire

/* File: sfrc_host.sv */
/*
  sfrc_host: host end of the serial flash read link. Software programs
  a transfer over APB (opcode, tx bits, dummy clocks, rx bytes, lane
  widths) and starts it; sclk is pclk divided, idle low.
  Assumes zero-wait APB with one access cycle; single-rate only.
*/
`timescale 1ns/1ps
`default_nettype none
module sfrc_host
  import sfrc_pkg::*;
#(
  parameter int HALF = SCLK_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sfrc_link_if.host lnk
);
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

  typedef struct packed {
    sfrc_hst_t st;
    logic op_en;
    logic [1:0] op_w;
    logic [1:0] tx_w;
    logic [1:0] rx_w;
    logic [5:0] tx_len;
    logic [3:0] dum;
    logic [7:0] rx_bytes;
    logic [7:0] opc;
    logic [31:0] txd;
    logic [31:0] rxd;
    logic [39:0] sh;
    logic [10:0] rem;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic [3:0] o;
    logic [3:0] oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sfrc_hstate_t;

  localparam sfrc_hstate_t HST_RST = '{st: H_IDLE, cs_n: 1'b1,
                                       default: '0};

  sfrc_hstate_t q;
  sfrc_hstate_t d;
  logic [3:0] io_s;
  logic busy;
  logic start;
  logic exit_req;
  logic drv;
  logic wr;
  logic [2:0] n;
  sfrc_hst_t nx_dum;
  sfrc_hst_t nx_tx;
  sfrc_hst_t nx_op;
  sfrc_hst_t nx;

  sfrc_sync #(.W(4), .RST(4'hf)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(lnk.io),
    .dout(io_s)
  );

  function automatic logic [10:0] rem_for(input sfrc_hst_t p,
                                          input logic [5:0] tl,
                                          input logic [3:0] dm,
                                          input logic [7:0] rb);
    case (p)
      H_OPC: rem_for = 11'h008;
      H_TX: rem_for = 11'(tl);
      H_DUM: rem_for = 11'(dm);
      H_RX: rem_for = {rb, 3'h0};
      default: rem_for = '0;
    endcase
  endfunction : rem_for

  assign busy = q.st != H_IDLE;

  always_comb begin
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    start = 1'b0;
    exit_req = 1'b0;
    drv = 1'b0;
    if (psel && !penable) begin
      d.pready = 1'b1;
      case (paddr)
        H_CFG: d.prdata = {4'h0, q.rx_bytes, q.dum, 2'h0, q.tx_len, 1'b0,
                           q.rx_w, q.tx_w, q.op_w, q.op_en};
        H_OPCODE: d.prdata = {24'h000000, q.opc};
        H_TXD: d.prdata = q.txd;
        H_CMD: d.prdata = {31'h00000000, busy};
        H_RXD: d.prdata = q.rxd;
        default: begin
          d.prdata = '0;
          d.pslverr = 1'b1;
        end
      endcase
    end
    // setup is refused while a transfer runs, so fields stay stable
    wr = psel & penable & q.pready & pwrite & ~q.pslverr & ~busy;
    if (wr) begin
      case (paddr)
        H_CFG: begin
          d.op_en = pwdata[OPEN_POS];
          d.op_w = pwdata[OPW_LO +: 2];
          d.tx_w = pwdata[TXW_LO +: 2];
          d.rx_w = pwdata[RXW_LO +: 2];
          d.tx_len = pwdata[TXLEN_LO +: 6];
          d.dum = pwdata[DUM_LO +: 4];
          d.rx_bytes = pwdata[RXB_LO +: 8];
        end
        H_OPCODE: d.opc = pwdata[7:0];
        H_TXD: d.txd = pwdata;
        H_CMD: begin
          start = pwdata[START_POS] | pwdata[EXIT_POS];
          exit_req = pwdata[EXIT_POS];
        end
        default: ;
      endcase
    end
    if (exit_req) begin
      d.op_en = 1'b0; // [RL20]
      d.tx_w = W1; // [RL20]
      d.tx_len = EXIT_BITS; // [RL20]
      d.dum = '0;
      d.rx_bytes = '0;
    end
    nx_dum = (d.rx_bytes == '0) ? H_END : H_RX;
    nx_tx = (d.dum == '0) ? nx_dum : H_DUM;
    nx_op = (d.tx_len == '0) ? nx_tx : H_TX;
    case (q.st)
      H_OPC: nx = nx_op;
      H_TX: nx = nx_tx;
      H_DUM: nx = nx_dum;
      default: nx = H_END;
    endcase
    case (q.st)
      H_OPC: n = lane_n(q.op_w);
      H_TX: n = lane_n(q.tx_w);
      H_RX: n = lane_n(q.rx_w);
      default: n = 3'h1;
    endcase
    if (start) begin
      d.st = d.op_en ? H_OPC : nx_op;
      d.rem = rem_for(d.st, d.tx_len, d.dum, d.rx_bytes);
      d.sh = exit_req ? '1 : {d.opc, d.txd}; // [RL20]
      d.cs_n = 1'b0;
      d.sclk = 1'b0;
      d.div = '0;
      drv = 1'b1;
    end else if (busy) begin
      if (q.div == HALF_M1) begin
        d.div = '0;
        if (q.sclk) begin
          d.sclk = 1'b0;
          drv = 1'b1;
        end else if (q.st == H_END) begin
          d.cs_n = 1'b1;
          d.st = H_IDLE;
        end else begin
          d.sclk = 1'b1;
          if (q.st == H_RX) begin
            d.rxd = (q.rxd << n) | 32'(in_bits(io_s, q.rx_w, 1'b1));
          end
          if (q.st == H_OPC || q.st == H_TX) begin
            d.sh = q.sh << n;
          end
          d.rem = q.rem - 11'(n);
          if (d.rem == '0) begin
            d.st = nx;
            d.rem = rem_for(nx, q.tx_len, q.dum, q.rx_bytes);
          end
        end
      end else begin
        d.div = q.div + 8'h01;
      end
    end
    if (drv) begin
      case (d.st)
        H_OPC: begin
          d.o = top_bits(d.sh[39:32], d.op_w, 1'b0);
          d.oe = lane_mask(d.op_w, 1'b0);
        end
        H_TX: begin
          d.o = top_bits(d.sh[39:32], d.tx_w, 1'b0);
          d.oe = lane_mask(d.tx_w, 1'b0);
        end
        default: begin
          d.o = '0;
          d.oe = '0; // [RL14]
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= HST_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign lnk.sclk = q.sclk;
  assign lnk.cs_n = q.cs_n;
  assign lnk.host_o = q.o;
  assign lnk.host_oe = q.oe;
endmodule : sfrc_host
`default_nettype wire

/* File: sfrc_chk.sv */
/*
  sfrc_chk: concurrent checks on the link between host and device ends.
  Assumes the link signals arrive as plain inputs in the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sfrc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_o,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe
);
  logic sclk_q;
  logic [3:0] fall_q;
  // pclk cycles since sclk fell; saturates so idle never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      fall_q <= 4'hf;
    end else begin
      sclk_q <= sclk;
      if (sclk_q && !sclk)
        fall_q <= 4'h1;
      else if (fall_q != 4'hf)
        fall_q <= fall_q + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_quiet;
    (dev_oe == 4'h0) [*8];
  endsequence
  sequence s_low;
    (!sclk) [*8];
  endsequence
  AST_NO_FIGHT: assert property ((dev_oe & host_oe) == 4'h0)
    else $error("lane driven by both ends");
  AST_SEL_QUIET: assert property ($fell(cs_n) |-> s_quiet)
    else $error("device drives lanes at select");
  AST_DESEL_OFF: assert property (cs_n [*8] |=> dev_oe == 4'h0)
    else $error("device drives lanes while deselected");
  AST_OE_ON_FALL: assert property ((dev_oe != 4'h0 &&
    $past(dev_oe) == 4'h0) |-> (fall_q >= 4'h2 && fall_q <= 4'h8))
    else $error("lane enable not after a falling edge");
  AST_DATA_ON_FALL: assert property (($changed(dev_o) &&
    dev_oe != 4'h0 && $past(dev_oe) != 4'h0) |->
    (fall_q >= 4'h2 && fall_q <= 4'h8))
    else $error("output data changed away from a falling edge");
  AST_LANE_SETS: assert property (
    dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal set of device lanes");
  AST_IDLE_LOW: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  AST_FIRST_RISE: assert property ($fell(cs_n) |-> s_low)
    else $error("link clock rose too soon after select");
  AST_HALF_HIGH: assert property ($rose(sclk) |-> sclk [*8])
    else $error("link clock high phase too short");
  AST_HOLD_ON_RISE: assert property ($rose(sclk) |-> $stable(host_o))
    else $error("host data moved at sampling edge");
endmodule : sfrc_chk
`default_nettype wire

/* File: tb_top.sv */
/*
  tb_top: drives the host end over APB, loads the device array and
  checks received bytes and device status after each link transfer except the dual I/O read before the exit.
  Assumes one transfer at a time and the host's default divider.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfrc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic busy_in = 1'b0, fl = 1'b0, mem_we = 1'b0, cont;
  logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, st1, st2;
  logic [1:0] rparam;
  int miscompares = 0, num_checks = 0;
  sfrc_link_if lnk ();
  sfrc_host i_sfrc_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  sfrc_dev i_sfrc_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .busy_in(busy_in), .four_lane_command_mode(fl), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .status1(st1),
    .status2(st2), .read_param(rparam), .cont_mode(cont));
  sfrc_chk i_sfrc_chk (.pclk(pclk), .presetn(presetn), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .host_o(lnk.host_o), .host_oe(lnk.host_oe),
    .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe));
  always #2.5 pclk = ~pclk;
  function automatic logic [7:0] em(input logic [7:0] a);
    em = a ^ 8'h5a;
  endfunction : em
  function automatic logic [31:0] cf(input logic oe, input logic [1:0] ow,
    input logic [1:0] tw, input logic [1:0] rw, input logic [5:0] tl,
    input logic [3:0] dm, input logic [7:0] rb);
    cf = {4'h0, rb, dm, 2'h0, tl, 1'b0, rw, tw, ow, oe};
  endfunction : cf
  task automatic complete_run;
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic go_wait;
    apb(H_CMD, 1'b0, 32'h0);
    while (rd[0] !== 1'b0)
      apb(H_CMD, 1'b0, 32'h0);
    apb(H_RXD, 1'b0, 32'h0);
  endtask : go_wait
  task automatic run(input logic [7:0] op, input logic [31:0] c,
    input logic [31:0] tx);
    apb(H_OPCODE, 1'b1, {24'h0, op});
    apb(H_TXD, 1'b1, tx);
    apb(H_CFG, 1'b1, c);
    apb(H_CMD, 1'b1, 32'h1);
    go_wait();
  endtask : run
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge pclk);
      mem_we <= 1'b1;
      mem_addr <= i[7:0];
      mem_wdata <= em(i[7:0]);
    end
    @(posedge pclk);
    mem_we <= 1'b0;
    chk({14'h0, rparam}, 16'h0);
    apb(12'h020, 1'b0, 32'h0);
    chk({15'h0, err}, 16'h1);
    // tx bits leave msb first from {opcode, txd}: address sits high
    run(OP_READ, cf(1'b1, W1, W1, W1, 6'h18, 4'h0, 8'h02), 32'h00001000);
    chk(rd[15:0], {em(8'h10), em(8'h11)});
    run(OP_QUAD, cf(1'b1, W1, W1, W4, 6'h18, 4'h8, 8'h01), 32'h20);
    chk({8'h0, rd[7:0]}, 16'h00ff);
    run(OP_WSR, cf(1'b1, W1, W1, W1, 6'h10, 4'h0, 8'h00), 32'h3c020000);
    chk({st1, st2}, 16'h3c02);
    run(OP_WSR, cf(1'b1, W1, W1, W1, 6'h08, 4'h0, 8'h00), 32'ha5000000);
    chk({st1, st2}, 16'ha502);
    run(OP_QUAD, cf(1'b1, W1, W1, W4, 6'h18, 4'h8, 8'h01), 32'h00002000);
    chk({8'h0, rd[7:0]}, {8'h0, em(8'h20)});
    run(OP_FAST, cf(1'b1, W1, W1, W1, 6'h18, 4'h8, 8'h01), 32'h00003100);
    chk({8'h0, rd[7:0]}, {8'h0, em(8'h31)});
    run(OP_DUAL, cf(1'b1, W1, W1, W2, 6'h18, 4'h8, 8'h01), 32'h00004200);
    chk({8'h0, rd[7:0]}, {8'h0, em(8'h42)});
    busy_in <= 1'b1;
    run(OP_READ, cf(1'b1, W1, W1, W1, 6'h18, 4'h0, 8'h01), 32'h10);
    busy_in <= 1'b0;
    chk({8'h0, rd[7:0]}, 16'h00ff);
    chk({st1, st2}, 16'ha502);
    // low nibble of the continuous bits set to show it is ignored
    run(OP_DIO, cf(1'b1, W1, W2, W2, 6'h20, 4'h0, 8'h01), 32'h502f);
    chk({8'h0, rd[7:0]}, {8'h0, em(8'h50)});
    chk({15'h0, cont}, 16'h1);
    // opcode skipped: address goes out straight after select
    run(8'h00, cf(1'b0, W1, W2, W2, 6'h20, 4'h0, 8'h01), 32'h00610000);
    chk({8'h0, rd[7:0]}, {8'h0, em(8'h61)});
    chk({15'h0, cont}, 16'h0);
    run(OP_DIO, cf(1'b1, W1, W2, W2, 6'h20, 4'h0, 8'h01), 32'h5020);
    apb(H_CMD, 1'b1, 32'h2);
    go_wait();
    chk({15'h0, cont}, 16'h0);
    fl <= 1'b1;
    run(OP_READ, cf(1'b1, W4, W4, W4, 6'h18, 4'h0, 8'h01), 32'h10);
    chk({8'h0, rd[7:0]}, 16'h00ff);
    run(OP_SETP, cf(1'b1, W4, W4, W1, 6'h08, 4'h0, 8'h00), 32'h30000000);
    chk({14'h0, rparam}, 16'h3);
    run(OP_FAST, cf(1'b1, W4, W4, W4, 6'h18, 4'h8, 8'h01), 32'h00007200);
    chk({8'h0, rd[7:0]}, {8'h0, em(8'h72)});
    run(OP_RST, cf(1'b1, W4, W1, W1, 6'h00, 4'h0, 8'h00), 32'h0);
    chk({14'h0, rparam}, 16'h0);
    run(OP_FAST, cf(1'b1, W4, W4, W4, 6'h18, 4'h2, 8'h01), 32'h00007300);
    chk({8'h0, rd[7:0]}, {8'h0, em(8'h73)});
    fl <= 1'b0;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
